// ==== logic/nand_prog_host.sv ====
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Pages of a block programmed ascending only
// - At most four programs per page
// - Program is 80h, five addresses, data, 10h
// - While busy only 70h and FFh issued
// - 85h with new column continues data load
// - Queue planes then confirm programs all together
// - Two-plane error needs per-plane 78h check
// - Plane select low first, high second
// - Column valid for each plane
// - Same operation type on both planes (the host does not check this)
// - Copy back within one plane, 00h/35h first
// - Random input may modify copy-back data
// - Check copied data with ECC first (left to software; the host does not check this)
module nand_prog_host
  import nand_host_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int WB_CYCLES     = WB_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Flash pins
  output logic             ce_n_out,
  output logic             cle_out,
  output logic             ale_out,
  output logic             we_n_out,
  output logic             read_strobe_n_out,
  output logic      [7:0]  io_out,
  output logic             io_oe_out,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy_n_output_in
);

  logic             rst_s1, rst_n;
  logic             rdy_s1, rdy;
  logic [7:0]       io_s1, io_s2;
  pin_state_t       st;
  seq_state_t       seq;
  logic [7:0]       cnt;
  logic [2:0]       op_q;
  logic [7:0]       rd_byte;
  logic [ERR_W-1:0] err, ev;
  logic [2:0]       acnt;
  logic             is_read, is_rand, cb_ready, cb_plane, two_plane;
  logic             stat_mode, last_tp;
  logic [7:0]       row1;
  logic [10:0]      blk, last_blk;
  logic [5:0]       last_page;
  logic [2:0]       pcount;
  logic             acc, wr, go, refuse, issue, rd_done;
  logic [2:0]       op;
  logic [7:0]       cbyte;
  logic [2:0]       need;

  // All checks run on the system clock and rest during reset
  default clocking chk_clk @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdy_s1 <= 1'b0;
      rdy    <= 1'b0;
      io_s1  <= 8'h00;
      io_s2  <= 8'h00;
    end else begin
      rdy_s1 <= ready_busy_n_output_in;
      rdy    <= rdy_s1;
      io_s1  <= io_in;
      io_s2  <= io_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, effect at the edge that sees pready
  assign acc   = psel_in && penable_in && pready_out;
  assign wr    = acc && pwrite_in;
  assign op    = pwdata_in[CTRL_OP_LSB +: 3];
  assign cbyte = pwdata_in[CTRL_BYTE_LSB +: 8];
  assign go    = wr && paddr_in == OFF_CTRL && st == ST_IDLE;
  // Only status read and reset may reach a busy device
  assign refuse = op != OP_WAIT && !rdy &&
                  !(op == OP_CMD && (cbyte == CMD_STATUS ||
                                     cbyte == CMD_RESET));
  assign issue = go && !refuse && op != OP_WAIT;
  assign need  = is_rand ? COL_CYCLES : ADDR_CYCLES;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in && penable_in && !pready_out;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      if (psel_in && penable_in && !pready_out) begin
        if (paddr_in == OFF_CTRL) begin
          pslverr_out <= pwrite_in && st != ST_IDLE;
        end else if (paddr_in == OFF_STATUS) begin
          prdata_out <= {16'h0000, rd_byte, 2'b00, stat_mode, two_plane,
                         cb_ready, seq == SQ_DATA, rdy, st != ST_IDLE};
        end else if (paddr_in == OFF_ERR) begin
          prdata_out <= {{(32-ERR_W){1'b0}}, err};
        end else begin
          pslverr_out <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sequencer: setup, strobe low, strobe high
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st                <= ST_IDLE;
      cnt               <= 8'h00;
      op_q              <= 3'h0;
      ce_n_out          <= 1'b1;
      cle_out           <= 1'b0;
      ale_out           <= 1'b0;
      we_n_out          <= 1'b1;
      read_strobe_n_out <= 1'b1;
      io_out            <= 8'h00;
      io_oe_out         <= 1'b0;
      rd_byte           <= 8'h00;
    end else begin
      case (st)
        ST_IDLE: begin
          if (go && op == OP_WAIT) begin
            // Busy may take a while to show on the pin
            st  <= ST_WAIT;
            cnt <= 8'(WB_CYCLES - 1);
          end else if (issue) begin
            st        <= ST_SETUP;
            op_q      <= op;
            ce_n_out  <= 1'b0;
            cle_out   <= op == OP_CMD;
            ale_out   <= op == OP_ADDR;
            io_out    <= cbyte;
            io_oe_out <= op != OP_DRD;
          end
        end
        ST_SETUP: begin
          st  <= ST_LOW;
          cnt <= 8'(STROBE_CYCLES - 1);
          if (op_q == OP_DRD) begin
            read_strobe_n_out <= 1'b0;
          end else begin
            we_n_out <= 1'b0;
          end
        end
        ST_LOW: begin
          if (cnt == 8'h00) begin
            st                <= ST_HIGH;
            cnt               <= 8'(STROBE_CYCLES - 1);
            we_n_out          <= 1'b1;
            read_strobe_n_out <= 1'b1;
            // Limitation: data is sampled two cycles after it reached the pin
            if (op_q == OP_DRD) begin
              rd_byte <= io_s2;
            end
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_HIGH: begin
          if (cnt == 8'h00) begin
            st        <= ST_IDLE;
            ce_n_out  <= 1'b1;
            cle_out   <= 1'b0;
            ale_out   <= 1'b0;
            io_oe_out <= 1'b0;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_WAIT: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else if (rdy) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  assign rd_done = st == ST_LOW && cnt == 8'h00 && op_q == OP_DRD;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence tracking
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      seq       <= SQ_IDLE;
      acnt      <= 3'h0;
      is_read   <= 1'b0;
      is_rand   <= 1'b0;
      cb_ready  <= 1'b0;
      cb_plane  <= 1'b0;
      two_plane <= 1'b0;
      stat_mode <= 1'b0;
      last_tp   <= 1'b0;
      row1      <= 8'h00;
      blk       <= 11'h000;
      last_blk  <= 11'h7FF;
      last_page <= 6'h00;
      pcount    <= 3'h0;
    end else if (issue && op == OP_CMD) begin
      stat_mode <= cbyte == CMD_STATUS || cbyte == CMD_PLSTAT;
      if (cbyte == CMD_SETUP) begin
        seq     <= SQ_ADDR;
        acnt    <= 3'h0;
        is_read <= 1'b0;
        is_rand <= 1'b0;
      end else if (cbyte == CMD_RANDIN) begin
        // Column only inside a load, full address for copy back
        seq     <= SQ_ADDR;
        acnt    <= 3'h0;
        is_rand <= seq == SQ_DATA;
        is_read <= 1'b0;
      end else if (cbyte == CMD_READ) begin
        seq      <= SQ_ADDR;
        acnt     <= 3'h0;
        is_read  <= 1'b1;
        cb_ready <= 1'b0;
      end else if (cbyte == CMD_CBREAD) begin
        seq      <= SQ_IDLE;
        cb_ready <= is_read && acnt == ADDR_CYCLES;
        cb_plane <= row1[PLANE_SEL_BIT];
      end else if (cbyte == CMD_QUEUE) begin
        seq       <= SQ_IDLE;
        two_plane <= 1'b1;
      end else if (cbyte == CMD_CONFIRM) begin
        seq       <= SQ_IDLE;
        two_plane <= 1'b0;
        last_tp   <= two_plane;
        cb_ready  <= 1'b0;
        last_blk  <= blk;
        last_page <= row1[5:0];
        pcount    <= (blk == last_blk && row1[5:0] == last_page) ?
                     (pcount == 3'h7 ? pcount : pcount + 3'h1) : 3'h1;
      end else if (cbyte == CMD_RESET) begin
        seq       <= SQ_IDLE;
        cb_ready  <= 1'b0;
        two_plane <= 1'b0;
      end
    end else if (issue && op == OP_ADDR) begin
      if (acnt != ADDR_CYCLES) begin
        acnt <= acnt + 3'h1;
      end
      if (acnt == ROW1_IDX) begin
        row1 <= cbyte;
        blk  <= {blk[10:1], cbyte[7]};
      end else if (acnt == ROW2_IDX) begin
        blk <= {blk[10:9], cbyte, blk[0]};
      end else if (acnt == ROW3_IDX) begin
        blk <= {cbyte[1:0], blk[8:0]};
      end
      if (acnt + 3'h1 >= need && !is_read) begin
        seq <= SQ_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-side checks, reported as sticky errors
  always_comb begin
    ev = '0;
    ev[ERR_BUSY] = go && refuse;
    if (issue && op == OP_DWR && seq != SQ_DATA) begin
      ev[ERR_SEQ] = 1'b1;
    end
    if (issue && op == OP_ADDR &&
        !(seq == SQ_ADDR || (seq == SQ_DATA && is_rand))) begin
      ev[ERR_SEQ] = 1'b1;
    end
    // A column past the page end would wrap inside the plane
    if (issue && op == OP_ADDR && acnt == 3'h1 && cbyte > COL_HI_MAX) begin
      ev[ERR_SEQ] = 1'b1;
    end
    if (issue && op == OP_CMD) begin
      if ((cbyte == CMD_CONFIRM || cbyte == CMD_QUEUE) && seq != SQ_DATA) begin
        ev[ERR_SEQ] = 1'b1;
      end
      if (cbyte == CMD_RANDIN && seq != SQ_DATA && !cb_ready) begin
        ev[ERR_SEQ] = 1'b1;
      end
      if (cbyte == CMD_READ && two_plane) begin
        ev[ERR_SEQ] = 1'b1;
      end
      if (cbyte == CMD_QUEUE && !two_plane && row1[PLANE_SEL_BIT]) begin
        ev[ERR_PLANE] = 1'b1;
      end
      if (cbyte == CMD_CONFIRM) begin
        ev[ERR_PLANE] = two_plane && !row1[PLANE_SEL_BIT];
        ev[ERR_ORDER] = blk == last_blk && row1[5:0] < last_page;
        ev[ERR_PARTIAL] = blk == last_blk && row1[5:0] == last_page &&
                          pcount >= MAX_PARTIAL;
        ev[ERR_COPY] = cb_ready && !two_plane &&
                       row1[PLANE_SEL_BIT] != cb_plane;
      end
    end
    // A failing status after a two-plane program wants 78h
    ev[ERR_CHECK78] = rd_done && stat_mode && last_tp &&
                      |io_s2[1:0];
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      err <= '0;
    end else if (wr && paddr_in == OFF_ERR) begin
      err <= (err & ~pwdata_in[ERR_W-1:0]) | ev;
    end else begin
      err <= err | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_busy_refuse: assert property (
    go && refuse |=> st == ST_IDLE && err[ERR_BUSY])
    else $error("busy command was not refused");

  chk_pin_quiet_busy: assert property (
    go && refuse |-> ##1 we_n_out [*3])
    else $error("strobe toggled for refused cycle");

  chk_data_out_seq: assert property (
    issue && op == OP_DWR && seq != SQ_DATA |=> err[ERR_SEQ])
    else $error("data outside load phase not flagged");

  chk_load_enter: assert property (
    issue && op == OP_ADDR && acnt == 3'h4 && !is_read && !is_rand
    |=> seq == SQ_DATA)
    else $error("fifth address did not open data phase");

  chk_we_width: assert property (
    $fell(we_n_out) |-> !we_n_out [*3] ##1 we_n_out)
    else $error("write strobe width wrong");

  chk_order_flag: assert property (
    issue && op == OP_CMD && cbyte == CMD_CONFIRM && blk == last_blk &&
    row1[5:0] < last_page |=> err[ERR_ORDER])
    else $error("descending page not flagged");

  // Checked at the confirm, since software may clear the flag later
  chk_partial_count: assert property (
    issue && op == OP_CMD && cbyte == CMD_CONFIRM && blk == last_blk &&
    row1[5:0] == last_page && pcount >= MAX_PARTIAL |=> err[ERR_PARTIAL])
    else $error("fifth program not flagged");

  chk_plane_second: assert property (
    issue && op == OP_CMD && cbyte == CMD_CONFIRM && two_plane &&
    !row1[PLANE_SEL_BIT] |=> err[ERR_PLANE])
    else $error("second plane address not high");

  chk_wait_ready: assert property (
    st == ST_WAIT && $past(st) == ST_WAIT && cnt == 8'h00 && rdy
    |=> st == ST_IDLE)
    else $error("wait did not end on ready");

  chk_copy_plane: assert property (
    issue && op == OP_CMD && cbyte == CMD_CONFIRM && cb_ready && !two_plane &&
    row1[PLANE_SEL_BIT] != cb_plane |=> err[ERR_COPY])
    else $error("cross-plane copy back not flagged");

endmodule // nand_prog_host
`default_nettype wire

// ==== logic/nand_host_pkg.sv ====
package nand_host_pkg;

  // Clock and pin timing
  localparam int CLK_MHZ       = 100;
  localparam int STROBE_NS     = 25;
  localparam int STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int WB_NS         = 100;
  localparam int WB_CYC        = (WB_NS * CLK_MHZ + 999) / 1000;

  // Register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ERR    = 8'h08;

  // Control register fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_BYTE_LSB = 8;

  // Bus cycle kinds written to the control register
  localparam logic [2:0] OP_CMD  = 3'h1;
  localparam logic [2:0] OP_ADDR = 3'h2;
  localparam logic [2:0] OP_DWR  = 3'h3;
  localparam logic [2:0] OP_DRD  = 3'h4;
  localparam logic [2:0] OP_WAIT = 3'h5;

  // Flash command bytes
  localparam logic [7:0] CMD_READ    = 8'h00;
  localparam logic [7:0] CMD_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_QUEUE   = 8'h11;
  localparam logic [7:0] CMD_CBREAD  = 8'h35;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_PLSTAT  = 8'h78;
  localparam logic [7:0] CMD_SETUP   = 8'h80;
  localparam logic [7:0] CMD_RANDIN  = 8'h85;
  localparam logic [7:0] CMD_RESET   = 8'hFF;

  // Address layout
  localparam logic [2:0] ADDR_CYCLES = 3'h5;
  localparam logic [2:0] COL_CYCLES  = 3'h2;
  localparam logic [2:0] ROW1_IDX    = 3'h2;
  localparam logic [2:0] ROW2_IDX    = 3'h3;
  localparam logic [2:0] ROW3_IDX    = 3'h4;
  localparam int PLANE_SEL_BIT       = 6;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  // Highest column high byte that still falls inside one page
  localparam logic [7:0] COL_HI_MAX  = 8'h08;

  // Error register bits
  localparam int ERR_BUSY    = 0;
  localparam int ERR_SEQ     = 1;
  localparam int ERR_ORDER   = 2;
  localparam int ERR_PARTIAL = 3;
  localparam int ERR_PLANE   = 4;
  localparam int ERR_COPY    = 5;
  localparam int ERR_CHECK78 = 6;
  localparam int ERR_W       = 7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW   = 3'b011,
    ST_HIGH  = 3'b010,
    ST_WAIT  = 3'b110
  } pin_state_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_ADDR = 2'b01,
    SQ_DATA = 2'b11
  } seq_state_t;

endpackage

// ==== testbench/nand_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module nand_flash_model #(
  parameter int PROG_NS = 400,
  parameter int QBSY_NS = 200,
  parameter int LOAD_NS = 150
) (
  // Flash pins from the host
  input  wire logic       ce_n_in,
  input  wire logic       cle_in,
  input  wire logic       ale_in,
  input  wire logic       we_n_in,
  input  wire logic       read_strobe_n_in,
  input  wire logic [7:0] io_in,
  // Bench control
  input  wire logic       fail_in,
  // Flash outputs
  output logic      [7:0] io_out,
  output logic            ready_busy_n_output_out
);
  logic [7:0]  page_reg [2][64];
  logic [7:0]  mem [int];
  logic [7:0]  abyte [5];
  logic [23:0] row;
  logic [5:0]  col;
  logic        plane, smode, queued, fail_st;
  logic [1:0]  qd;
  logic [7:0]  drv, last;
  int          acnt, bsy_ns;
  event        go;

  initial begin
    ready_busy_n_output_out = 1'b1;
    {smode, queued, fail_st, plane, qd, col} = '0;
    acnt = 0;
    drv = 8'h00;
    last = 8'h00;
  end
  assign row = {abyte[4], abyte[3], abyte[2]};
  ////////////////////////////////////////////////////////////////////////////
  // One timer drives the pin and status bits 6 and 5 alike
  always begin
    @(go);
    ready_busy_n_output_out = 1'b0;
    #(bsy_ns);
    ready_busy_n_output_out = 1'b1;
  end
  task automatic busy(input int ns);
    bsy_ns = ns;
    ->go;
  endtask
  function automatic int key(input logic [23:0] r, input int c);
    return int'({r, c[5:0]});
  endfunction
  // Both planes take page and block from the last address
  task automatic commit();
    logic [23:0] r;
    for (int p = 0; p < 2; p++) begin
      if (qd[p] || p == int'(plane)) begin
        r = row;
        r[6] = p[0];
        for (int c = 0; c < 64; c++) mem[key(r, c)] = page_reg[p][c];
      end
    end
  endtask
  always @(posedge we_n_in) begin
    if (!ce_n_in && cle_in) begin
      if (ready_busy_n_output_out || io_in == 8'h70 || io_in == 8'hFF) begin
        acnt = 0;
        case (io_in)
          8'h70: smode = 1'b1;
          8'h80: begin
            if (!queued) foreach (page_reg[p, c]) page_reg[p][c] = 8'hFF;
            smode = 1'b0;
          end
          8'h00, 8'h85: smode = 1'b0;
          8'h35: begin
            for (int c = 0; c < 64; c++) begin
              page_reg[plane][c] = mem.exists(key(row, c)) ? mem[key(row, c)] : 8'hFF;
            end
            busy(LOAD_NS);
          end
          8'h11: begin
            queued = 1'b1;
            qd[plane] = 1'b1;
            busy(QBSY_NS);
          end
          8'h10: begin
            commit();
            queued = 1'b0;
            qd = 2'b00;
            fail_st = fail_in;
            smode = 1'b1;
            busy(PROG_NS);
          end
          8'hFF: begin
            queued = 1'b0;
            qd = 2'b00;
            foreach (page_reg[p, c]) page_reg[p][c] = 'x;
            smode = 1'b0;
            busy(LOAD_NS);
          end
          default: ;
        endcase
      end
    end else if (!ce_n_in && ale_in) begin
      if (acnt < 5) abyte[acnt] = io_in;
      if (acnt == 0) col = io_in[5:0];
      if (acnt == 2) plane = io_in[6];
      acnt++;
    end else if (!ce_n_in) begin
      page_reg[plane][col] = io_in;
      col++;
    end
  end
  always @(negedge read_strobe_n_in) begin
    if (!ce_n_in) begin
      drv = smode ? {1'b1, {2{ready_busy_n_output_out}}, 4'h0, fail_st}
                  : page_reg[plane][col];
      if (!smode) col++;
    end
  end
  always @(posedge read_strobe_n_in) last = drv;
  // Released bus shows the inverse so a stale byte never passes
  assign io_out = (!ce_n_in && !read_strobe_n_in) ? drv : ~last;
endmodule // nand_flash_model
`default_nettype wire

// ==== testbench/nand_prog_host_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module nand_prog_host_test;
  import nand_host_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, fail, e;
  logic [7:0]  paddr, io_o, dev_io, bus, b, nb;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, ce_n, cle, ale, we_n, re_n, io_oe, rb;
  logic [7:0]  q0[$], q1[$];
  int          num_errors = 0;
  int          compares = 0;

  assign bus = io_oe ? io_o : dev_io;
  always #5 clk = ~clk;

  nand_prog_host dut (.clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .ce_n_out(ce_n), .cle_out(cle), .ale_out(ale),
    .we_n_out(we_n), .read_strobe_n_out(re_n), .io_out(io_o),
    .io_oe_out(io_oe), .io_in(bus), .ready_busy_n_output_in(rb));
  nand_flash_model partner (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale),
    .we_n_in(we_n), .read_strobe_n_in(re_n), .io_in(bus), .fail_in(fail),
    .io_out(dev_io), .ready_busy_n_output_out(rb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idle();
    do apb(1'b0, OFF_STATUS, 32'h0); while (r[0] !== 1'b0);
  endtask
  task automatic op(input logic [2:0] o, input logic [7:0] v);
    idle();
    apb(1'b1, OFF_CTRL, {16'h0, v, 5'h0, o});
  endtask
  task automatic cmd(input logic [7:0] v);
    op(OP_CMD, v);
  endtask
  task automatic adr(input logic [7:0] c, input logic [7:0] r1);
    logic [7:0] a [5] = '{c, 8'h00, r1, 8'h00, 8'h00};
    foreach (a[i]) op(OP_ADDR, a[i]);
  endtask
  task automatic rd(output logic [7:0] v);
    op(OP_DRD, 8'h00);
    idle();
    v = r[15:8];
  endtask
  task automatic errchk(input logic [31:0] exp);
    apb(1'b0, OFF_ERR, 32'h0);
    check("err reg", r, exp);
    apb(1'b1, OFF_ERR, 32'hFFFF_FFFF);
  endtask
  function automatic int key(input logic [7:0] r1, input int c);
    return int'({16'h0, r1, c[5:0]});
  endfunction
  task automatic load(input int n, inout logic [7:0] q[$]);
    for (int i = 0; i < n; i++) begin
      q.push_back(8'($urandom));
      op(OP_DWR, q[$]);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    $display("ERROR watchdog expected done seen timeout");
    summarize();
  end

  initial begin
    {clk, rst_n, psel, penable, pwrite, fail} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    r = $urandom(36);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    errchk(32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped err", e, 1'b1);
    check("unmapped data", r, 32'h0);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl read", r, 32'h0);
    $display("test reset done");
    // Program with a random input jump, then a refused command while busy
    cmd(CMD_SETUP);
    adr(8'h04, 8'h01);
    load(4, q0);
    cmd(CMD_RANDIN);
    op(OP_ADDR, 8'h0A);
    op(OP_ADDR, 8'h00);
    load(1, q0);
    cmd(CMD_CONFIRM);
    idle();
    check("ready pin", r[1], 1'b0);
    cmd(CMD_SETUP);
    errchk(32'h1 << ERR_BUSY);
    cmd(CMD_STATUS);
    op(OP_WAIT, 8'h00);
    rd(b);
    check("status", b, 8'hE0);
    rd(b);
    check("status again", b, 8'hE0);
    for (int i = 0; i < 4; i++) check("reg", partner.page_reg[0][4+i], q0[i]);
    check("reg jump", partner.page_reg[0][10], q0[4]);
    $display("test program done");
    // Lower page after higher page in the same block
    cmd(CMD_SETUP);
    adr(8'h00, 8'h00);
    op(OP_DWR, 8'h5A);
    cmd(CMD_CONFIRM);
    op(OP_WAIT, 8'h00);
    errchk(32'h1 << ERR_ORDER);
    $display("test order done");
    // Two planes, array reports a failure
    q0.delete();
    fail <= 1'b1;
    cmd(CMD_SETUP);
    adr(8'h00, 8'h83);
    load(2, q0);
    cmd(CMD_QUEUE);
    idle();
    check("plane queued", r[4], 1'b1);
    op(OP_WAIT, 8'h00);
    cmd(CMD_SETUP);
    adr(8'h00, 8'hC3);
    load(2, q1);
    cmd(CMD_CONFIRM);
    op(OP_WAIT, 8'h00);
    cmd(CMD_STATUS);
    rd(b);
    check("two plane status", b, 8'hE1);
    errchk(32'h1 << ERR_CHECK78);
    for (int i = 0; i < 2; i++) begin
      check("plane0", partner.mem[key(8'h83, i)], q0[i]);
      check("plane1", partner.mem[key(8'hC3, i)], q1[i]);
    end
    fail <= 1'b0;
    $display("test two plane done");
    // Copy back with one modified byte
    cmd(CMD_READ);
    adr(8'h00, 8'h83);
    cmd(CMD_CBREAD);
    op(OP_WAIT, 8'h00);
    for (int i = 0; i < 2; i++) begin
      rd(b);
      check("copy read", b, q0[i]);
    end
    check("copy loaded", r[3], 1'b1);
    nb = 8'($urandom);
    cmd(CMD_RANDIN);
    adr(8'h01, 8'h84);
    op(OP_DWR, nb);
    cmd(CMD_CONFIRM);
    op(OP_WAIT, 8'h00);
    cmd(CMD_STATUS);
    rd(b);
    check("copy status", b, 8'hE0);
    check("copy kept", partner.mem[key(8'h84, 0)], q0[0]);
    check("copy merged", partner.mem[key(8'h84, 1)], nb);
    errchk(32'h0);
    $display("test copy back done");
    // Error flags: page reuse, cross-plane copy, stray data, plane order
    for (int i = 0; i < 5; i++) begin
      cmd(CMD_SETUP);
      adr(8'h00, 8'h85);
      op(OP_DWR, 8'($urandom));
      cmd(CMD_CONFIRM);
      op(OP_WAIT, 8'h00);
    end
    errchk(32'h1 << ERR_PARTIAL);
    cmd(CMD_READ);
    adr(8'h00, 8'h85);
    cmd(CMD_CBREAD);
    op(OP_WAIT, 8'h00);
    cmd(CMD_RANDIN);
    adr(8'h00, 8'hC6);
    op(OP_DWR, 8'h00);
    cmd(CMD_CONFIRM);
    op(OP_WAIT, 8'h00);
    errchk(32'h1 << ERR_COPY);
    op(OP_DWR, 8'h00);
    errchk(32'h1 << ERR_SEQ);
    cmd(CMD_SETUP);
    adr(8'h00, 8'h87);
    op(OP_DWR, 8'h00);
    cmd(CMD_QUEUE);
    op(OP_WAIT, 8'h00);
    cmd(CMD_READ);
    errchk(32'h1 << ERR_SEQ);
    cmd(CMD_SETUP);
    adr(8'h00, 8'h87);
    op(OP_DWR, 8'h00);
    cmd(CMD_CONFIRM);
    op(OP_WAIT, 8'h00);
    errchk(32'h1 << ERR_PLANE);
    $display("test error flags done");
    summarize();
  end
endmodule // nand_prog_host_test
`default_nettype wire
